// ---- verilog/ecfg_regs.svh ----
// offsets, fields, reset values and timing counts of the configuration loader
`ifndef ECFG_REGS_SVH
`define ECFG_REGS_SVH
`define ECFG_CLK_NS        4
`define ECFG_SCK_HALF_NS   250
`define ECFG_SCK_HALF_CYC  (`ECFG_SCK_HALF_NS / `ECFG_CLK_NS)
`define ECFG_SETTLE_CYC    8
`define ECFG_CTRL          8'h00
`define ECFG_WDATA         8'h04
`define ECFG_RDATA         8'h08
`define ECFG_STATUS        8'h0C
`define ECFG_STRAPS        8'h10
`define ECFG_DBG_SRC       8'h14
`define ECFG_MEM_INDEX     8'h18
`define ECFG_MEM_DATA      8'h1C
`define ECFG_CTRL_GO       0
`define ECFG_CTRL_OP_LSB   1
`define ECFG_CTRL_ADDR_LSB 8
`define ECFG_STAT_BUSY     0
`define ECFG_STAT_DONE     1
`define ECFG_STAT_ENABLED  2
`define ECFG_STAT_LOADED   3
`define ECFG_OP_W          2
`define ECFG_ADDR_W        6
`define ECFG_DATA_W        16
`define ECFG_FRAME_W       25
`define ECFG_OP_READ       2'h2
`define ECFG_RDATA_RESET   32'h0000_0000
`endif

// ---- verilog/ecfg_pkg.sv ----
// types shared by the configuration loader files
package ecfg_pkg;
  typedef enum logic [1:0] {
    ECFG_RESET_WAIT,
    ECFG_IDLE,
    ECFG_FRAME,
    ECFG_GAP
  } ecfg_state_t;

  typedef enum logic [1:0] {
    ECFG_LANE_505,
    ECFG_LANE_606,
    ECFG_LANE_508
  } ecfg_lane_t;
endpackage

// ---- verilog/ecfg_sync.sv ----
// two-flop synchroniser for pins from outside the core clock
`timescale 1ns/1ps
module ecfg_sync
  import ecfg_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // pins and synchronised copy
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ecfg_sync_st_t;

  ecfg_sync_st_t st;
  ecfg_sync_st_t next_st;

  always_comb begin
    next_st.stage1 = pin;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_sync = st.stage2;
endmodule

// ---- verilog/ecfg_mem.sv ----
// word store for configuration words loaded from the serial memory
`timescale 1ns/1ps
module ecfg_mem
  import ecfg_pkg::*;
#(
  parameter int WORDS = 16,
  parameter int W     = 16,
  parameter int IDX_W = $clog2(WORDS)
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [W-1:0]     wr_data,
  // registered read port
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [W-1:0]     rd_data
);
  typedef struct packed {
    logic [WORDS-1:0][W-1:0] word;
    logic [W-1:0]            rd;
  } ecfg_mem_st_t;

  ecfg_mem_st_t st;
  ecfg_mem_st_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.word[wr_idx] = wr_data;
    end
    // read after write so a fresh word is seen at once
    next_st.rd = next_st.word[rd_idx];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;
endmodule

// ---- verilog/ecfg_top.sv ----
// serial configuration memory loader and strap capture
//
// Contract
// - device makes the four-wire memory clock
// - command, address, write data go out serially
// - read data captured serially from memory
// - select low during access, high otherwise
// - select pin strap: low bypasses memory
// - protocol strap: high I2C, low SMBus
// - debug pins 2:0 give operation mode
// - debug pins drive debug data afterwards
// - debug 4,3,0 share port select, payload
// - general pins choose 505, 606, 508 lanes
// - debug mode: general pins 4:0 select
// - payload strap high 512 bytes, low 256
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ecfg_regs.svh"
module ecfg_top
  import ecfg_pkg::*;
#(
  parameter int MEM_WORDS  = 16,
  parameter int LOAD_WORDS = 16
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // serial configuration memory
  input  wire logic        cfg_rom_clock_in,
  output logic             cfg_rom_clock_out,
  output logic             cfg_rom_clock_oe,
  output logic             cfg_rom_serial_out,
  input  wire logic        cfg_rom_serial_in,
  input  wire logic        cfg_rom_select_n_in,
  output logic             cfg_rom_select_n_out,
  output logic             cfg_rom_select_n_oe,
  // debug pins, straps during initialization
  input  wire logic [4:0]  debug_out_pins_in,
  output logic      [4:0]  debug_out_pins_out,
  output logic      [4:0]  debug_out_pins_oe,
  // other strap pins
  input  wire logic        mgmt_i2c_strap,
  input  wire logic [7:0]  gpio_in,
  // latched strap results
  output logic             strap_done,
  output logic             cfg_rom_enabled,
  output logic             mgmt_i2c_mode,
  output logic      [2:0]  operation_mode_strap,
  output logic      [1:0]  upstream_port_choice,
  output logic             payload_cap_strap,
  output ecfg_lane_t       lane_mode,
  output logic             debug_mode_active,
  output logic      [4:0]  debug_mode_code
);
  localparam int IDX_W = $clog2(MEM_WORDS);
  localparam int SYN_W = 17;
  localparam logic [7:0] HALF_LAST = 8'(`ECFG_SCK_HALF_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'(`ECFG_FRAME_W - 1);
  localparam logic [IDX_W-1:0] LOAD_LAST = IDX_W'(LOAD_WORDS - 1);

  typedef struct packed {
    ecfg_state_t                  state;
    logic [3:0]                   settle;
    logic [7:0]                   half_cnt;
    logic [4:0]                   bit_cnt;
    logic                         sck;
    logic                         sel_n;
    logic                         sout;
    logic                         rom_oe;
    logic [`ECFG_FRAME_W-1:0]     tx;
    logic [`ECFG_DATA_W-1:0]      rx;
    logic [`ECFG_DATA_W-1:0]      wdata;
    logic [`ECFG_DATA_W-1:0]      rdata;
    logic                         is_read;
    logic                         done;
    logic                         loading;
    logic                         loaded;
    logic [IDX_W-1:0]             load_idx;
    logic [IDX_W-1:0]             mem_idx;
    logic                         latched;
    logic                         rom_en;
    logic                         i2c;
    logic [2:0]                   opm;
    logic [1:0]                   ups;
    logic                         pl512;
    ecfg_lane_t                   lane;
    logic                         dbg_act;
    logic [4:0]                   dbg_code;
    logic [4:0]                   dbg_src;
    logic [4:0]                   dbg_o;
    logic [4:0]                   dbg_oe;
    logic [31:0]                  rd;
  } ecfg_top_st_t;

  ecfg_top_st_t st;
  ecfg_top_st_t next_st;

  logic [SYN_W-1:0]        syn;
  logic                    rom_in;
  logic                    sel_pin;
  logic                    clk_pin;
  logic [4:0]              dbg_pin;
  logic                    i2c_pin;
  logic [7:0]              gpio_pin;
  logic                    mem_we;
  logic [`ECFG_DATA_W-1:0] mem_rd;

  ecfg_sync #(
    .W (SYN_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pin      ({cfg_rom_serial_in, cfg_rom_select_n_in, cfg_rom_clock_in,
                debug_out_pins_in, mgmt_i2c_strap, gpio_in}),
    .pin_sync (syn)
  );

  assign {rom_in, sel_pin, clk_pin, dbg_pin, i2c_pin, gpio_pin} = syn;

  ecfg_mem #(
    .WORDS (MEM_WORDS),
    .W     (`ECFG_DATA_W),
    .IDX_W (IDX_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wr_en   (mem_we),
    .wr_idx  (st.load_idx),
    .wr_data (next_st.rdata),
    .rd_idx  (next_st.mem_idx),
    .rd_data (mem_rd)
  );

  // lane arrangement from general pins 6:5; 1x means 508
  function automatic ecfg_lane_t lane_decode(input logic [1:0] code);
    unique case (code)
      2'b00:   lane_decode = ECFG_LANE_505;
      2'b01:   lane_decode = ECFG_LANE_606;
      default: lane_decode = ECFG_LANE_508;
    endcase
  endfunction

  // five-bit debug word picked by a selection code
  function automatic logic [4:0] debug_pick(input logic [4:0] code, input ecfg_top_st_t s, input logic din,
                                            input logic ck);
    unique case (code[1:0])
      2'b00:   debug_pick = {s.sel_n, s.sck, s.sout, din, s.state != ECFG_IDLE};
      2'b01:   debug_pick = s.bit_cnt;
      2'b10:   debug_pick = {s.done, s.loaded, s.rom_en, s.i2c, ck};
      default: debug_pick = 5'(s.load_idx);
    endcase
  endfunction

  // one frame: start bit, opcode, address, data
  function automatic logic [`ECFG_FRAME_W-1:0] frame(input logic [`ECFG_OP_W-1:0] op,
                                                     input logic [`ECFG_ADDR_W-1:0] addr,
                                                     input logic [`ECFG_DATA_W-1:0] data);
    frame = {1'b1, op, addr, data};
  endfunction

  always_comb begin
    logic                     half_end;
    logic                     start;
    logic [`ECFG_FRAME_W-1:0] tx_new;
    logic                     rd_new;
    half_end = st.half_cnt == HALF_LAST;
    start    = 1'b0;
    tx_new   = '0;
    rd_new   = 1'b0;
    next_st  = st;
    mem_we   = 1'b0;
    next_st.half_cnt = half_end ? 8'h00 : st.half_cnt + 8'h01;

    unique case (st.state)
      ECFG_RESET_WAIT: begin
        // pins read only after the synchroniser has filled
        next_st.settle = st.settle + 4'h1;
        if (st.settle == 4'(`ECFG_SETTLE_CYC - 1)) begin
          next_st.latched  = 1'b1;
          next_st.rom_en   = sel_pin;
          next_st.i2c      = i2c_pin;
          next_st.opm      = dbg_pin[2:0];
          next_st.ups      = dbg_pin[4:3];
          next_st.pl512    = dbg_pin[0];
          next_st.lane     = lane_decode(gpio_pin[6:5]);
          next_st.dbg_act  = dbg_pin[2:0] != 3'h0;
          next_st.dbg_code = gpio_pin[4:0];
          next_st.dbg_oe   = 5'h1F;
          next_st.rom_oe   = sel_pin;
          next_st.sel_n    = 1'b1;
          next_st.state    = ECFG_IDLE;
          if (sel_pin && LOAD_WORDS > 0) begin
            next_st.loading  = 1'b1;
            next_st.load_idx = '0;
            start  = 1'b1;
            rd_new = 1'b1;
            tx_new = frame(`ECFG_OP_READ, '0, '0);
          end
        end
      end
      ECFG_IDLE: begin
        if (reg_write && reg_addr == `ECFG_CTRL && reg_wdata[`ECFG_CTRL_GO] && st.rom_en) begin
          start  = 1'b1;
          rd_new = reg_wdata[`ECFG_CTRL_OP_LSB +: `ECFG_OP_W] == `ECFG_OP_READ;
          tx_new = frame(reg_wdata[`ECFG_CTRL_OP_LSB +: `ECFG_OP_W],
                         reg_wdata[`ECFG_CTRL_ADDR_LSB +: `ECFG_ADDR_W], st.wdata);
        end
      end
      ECFG_FRAME: begin
        if (half_end) begin
          next_st.sck = ~st.sck;
          if (st.sck) begin
            // capture late in the high phase to cover the synchroniser delay
            next_st.rx = {st.rx[`ECFG_DATA_W-2:0], rom_in};
            next_st.tx = {st.tx[`ECFG_FRAME_W-2:0], 1'b0};
            next_st.sout = st.tx[`ECFG_FRAME_W-2];
            next_st.bit_cnt = st.bit_cnt + 5'h01;
            if (st.bit_cnt == BIT_LAST) begin
              next_st.state = ECFG_GAP;
              next_st.sel_n = 1'b1;
              next_st.sout  = 1'b0;
              if (st.is_read) begin
                next_st.rdata = {st.rx[`ECFG_DATA_W-2:0], rom_in};
              end
              mem_we = st.loading;
            end
          end
        end
      end
      ECFG_GAP: begin
        // select stays high a full half period between frames
        if (half_end) begin
          next_st.state = ECFG_IDLE;
          if (st.loading) begin
            if (st.load_idx == LOAD_LAST) begin
              next_st.loading = 1'b0;
              next_st.loaded  = 1'b1;
            end else begin
              next_st.load_idx = st.load_idx + 1'b1;
              start  = 1'b1;
              rd_new = 1'b1;
              tx_new = frame(`ECFG_OP_READ, `ECFG_ADDR_W'(st.load_idx + 1'b1), '0);
            end
          end else begin
            next_st.done = 1'b1;
          end
        end
      end
    endcase

    if (start) begin
      next_st.state    = ECFG_FRAME;
      next_st.tx       = tx_new;
      next_st.sout     = tx_new[`ECFG_FRAME_W-1];
      next_st.is_read  = rd_new;
      next_st.sel_n    = 1'b0;
      next_st.sck      = 1'b0;
      next_st.half_cnt = 8'h00;
      next_st.bit_cnt  = 5'h00;
    end

    // register writes other than the frame launch
    if (reg_write) begin
      unique case (reg_addr)
        `ECFG_WDATA:     next_st.wdata = reg_wdata[`ECFG_DATA_W-1:0];
        `ECFG_DBG_SRC:   next_st.dbg_src = reg_wdata[4:0];
        `ECFG_MEM_INDEX: next_st.mem_idx = reg_wdata[IDX_W-1:0];
        `ECFG_STATUS: begin
          // a frame ending in the same cycle keeps its done flag
          if (reg_wdata[`ECFG_STAT_DONE] && !(st.state == ECFG_GAP && half_end && !st.loading)) begin
            next_st.done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // debug pins carry internal state once straps are taken
    if (st.latched) begin
      next_st.dbg_o = debug_pick(st.dbg_act ? st.dbg_code : st.dbg_src, st, rom_in, clk_pin);
    end

    next_st.rd = `ECFG_RDATA_RESET;
    if (reg_read) begin
      unique case (reg_addr)
        `ECFG_CTRL:      next_st.rd = 32'h0000_0000;
        `ECFG_WDATA:     next_st.rd = 32'(st.wdata);
        `ECFG_RDATA:     next_st.rd = 32'(st.rdata);
        `ECFG_STATUS:    next_st.rd = 32'({st.loaded, st.rom_en, st.done, st.state != ECFG_IDLE});
        `ECFG_STRAPS:    next_st.rd = 32'({st.dbg_code, st.dbg_act, st.lane, st.pl512, st.ups, st.opm,
                                           st.i2c, st.rom_en});
        `ECFG_DBG_SRC:   next_st.rd = 32'(st.dbg_src);
        `ECFG_MEM_INDEX: next_st.rd = 32'(st.mem_idx);
        `ECFG_MEM_DATA:  next_st.rd = 32'(mem_rd);
        default:         next_st.rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st       <= '0;
      st.sel_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata            = st.rd;
  assign cfg_rom_clock_out    = st.sck;
  assign cfg_rom_clock_oe     = st.rom_oe;
  assign cfg_rom_serial_out   = st.sout;
  assign cfg_rom_select_n_out = st.sel_n;
  assign cfg_rom_select_n_oe  = st.rom_oe;
  assign debug_out_pins_out   = st.dbg_o;
  assign debug_out_pins_oe    = st.dbg_oe;
  assign strap_done           = st.latched;
  assign cfg_rom_enabled      = st.rom_en;
  assign mgmt_i2c_mode        = st.i2c;
  assign operation_mode_strap = st.opm;
  assign upstream_port_choice = st.ups;
  assign payload_cap_strap    = st.pl512;
  assign lane_mode            = st.lane;
  assign debug_mode_active    = st.dbg_act;
  assign debug_mode_code      = st.dbg_code;
endmodule

// ---- verif/ecfg_top_sva.sv ----
// port assertions for the configuration loader
`timescale 1ns/1ps
module ecfg_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // memory pins and debug pin enables
  input wire logic       cfg_rom_clock_out,
  input wire logic       cfg_rom_clock_oe,
  input wire logic       cfg_rom_serial_out,
  input wire logic       cfg_rom_select_n_out,
  input wire logic       cfg_rom_select_n_oe,
  input wire logic [4:0] debug_out_pins_oe,
  // strap results
  input wire logic       strap_done,
  input wire logic       cfg_rom_enabled,
  input wire logic [2:0] operation_mode_strap,
  input wire logic       debug_mode_active,
  input wire logic [4:0] debug_mode_code
);
  logic       clk_q;
  logic       sel_q;
  logic [7:0] half_cnt;
  logic [7:0] gap_cnt;
  logic [4:0] rise_cnt;

  // run lengths saturate so long idle spans never wrap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_q    <= 1'b0;
      sel_q    <= 1'b1;
      half_cnt <= 8'h00;
      gap_cnt  <= 8'hFF;
      rise_cnt <= 5'h00;
    end else begin
      clk_q    <= cfg_rom_clock_out;
      sel_q    <= cfg_rom_select_n_out;
      half_cnt <= (clk_q != cfg_rom_clock_out) ? 8'h01 : half_cnt + 8'(half_cnt != 8'hFF);
      gap_cnt  <= (sel_q != cfg_rom_select_n_out) ? 8'h01 : gap_cnt + 8'(gap_cnt != 8'hFF);
      rise_cnt <= (sel_q && !cfg_rom_select_n_out) ? 5'h00 : rise_cnt + 5'(!clk_q && cfg_rom_clock_out);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  clk_high_len_a: assert property ($fell(cfg_rom_clock_out) |-> half_cnt == 8'h3E)
    else $error("memory clock high phase not 62 cycles");
  clk_in_frame_a: assert property ($rose(cfg_rom_clock_out) |-> !cfg_rom_select_n_out)
    else $error("memory clock rose outside a frame");
  sout_edge_a: assert property ($changed(cfg_rom_serial_out) && !cfg_rom_select_n_out
    |-> $fell(cfg_rom_clock_out) || $fell(cfg_rom_select_n_out))
    else $error("serial out moved away from falling clock");
  frame_bits_a: assert property ($rose(cfg_rom_select_n_out) |-> rise_cnt == 5'h19)
    else $error("frame did not hold 25 clock rises");
  sel_gap_a: assert property ($fell(cfg_rom_select_n_out) |-> gap_cnt >= 8'h3E)
    else $error("select gap shorter than 62 cycles");
  sel_idle_a: assert property (!strap_done |-> cfg_rom_select_n_out)
    else $error("select low before straps latched");
  pin_drive_a: assert property ((cfg_rom_clock_oe && cfg_rom_select_n_oe) == (strap_done && cfg_rom_enabled))
    else $error("memory pin enables disagree with bypass strap");
  dbg_drive_a: assert property (debug_out_pins_oe == {5{strap_done}})
    else $error("debug pins driven before latch or idle after");
  dbg_mode_a: assert property (debug_mode_active == (strap_done && operation_mode_strap != 3'h0))
    else $error("debug mode flag disagrees with mode strap");
  strap_hold_a: assert property (strap_done && $past(strap_done)
    |-> $stable({cfg_rom_enabled, operation_mode_strap, debug_mode_code}))
    else $error("latched strap changed after latch");
endmodule

bind ecfg_top ecfg_chk chk_u (.ref_clk, .reset_n, .cfg_rom_clock_out, .cfg_rom_clock_oe, .cfg_rom_serial_out,
  .cfg_rom_select_n_out, .cfg_rom_select_n_oe, .debug_out_pins_oe, .strap_done, .cfg_rom_enabled,
  .operation_mode_strap, .debug_mode_active, .debug_mode_code);

// ---- verif/ecfg_rom_model.sv ----
// behavioural serial configuration memory on the far side of the loader
`timescale 1ns/1ps
module ecfg_rom_model (
  // memory pins
  input  wire logic sck,
  input  wire logic sel_n,
  input  wire logic sdi,
  output logic      sdo
);
  logic [15:0] mem [64];
  logic [24:0] shift;
  logic [15:0] word;
  logic        rd_op;
  int          rises;
  int          falls;

  initial begin
    sdo = 1'b0;
    for (int k = 0; k < 64; k++) mem[k] = 16'hA5C3 ^ 16'(k * 16'h0101);
  end
  always @(negedge sel_n) begin
    rises = 0;
    falls = 0;
    rd_op = 1'b0;
  end
  // released line must not keep showing the last bit
  always @(posedge sel_n) sdo = ~sdo;
  always @(posedge sck) if (!sel_n) begin
    shift = {shift[23:0], sdi};
    rises++;
    if (rises == 9 && shift[8:6] == 3'b110) begin
      rd_op = 1'b1;
      word  = mem[shift[5:0]];
    end
    if (rises == 25 && shift[24:22] == 3'b101) mem[shift[21:16]] = shift[15:0];
  end
  // read bits move on falling clock, msb first
  always @(negedge sck) if (!sel_n) begin
    falls++;
    if (falls >= 9 && rd_op) begin
      sdo  = word[15];
      word = {word[14:0], 1'b0};
    end
  end
endmodule

// ---- verif/test_ecfg_top.sv ----
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`include "ecfg_regs.svh"
module test_ecfg_top
  import ecfg_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic        reg_write;
  logic        reg_read;
  logic        sck, sck_oe, sout, sdi, seln, seln_oe, sel_strap, i2c_pin;
  logic        done, en, i2c, pay, act;
  logic [4:0]  dbg_pin, dbg_out, dbg_oe, code;
  logic [7:0]  gpio;
  logic [2:0]  opm;
  logic [1:0]  ups;
  ecfg_lane_t  lane;
  int          failures;
  int          samples_checked;
  logic [4:0]  dbg_t [3] = '{5'h11, 5'h08, 5'h1E};
  logic [7:0]  gp_t [3] = '{8'h15, 8'h2A, 8'h50};
  wire         sel_pin = seln_oe ? seln : sel_strap;
  wire         ck_pin = sck_oe & sck;

  always #2 ref_clk = ~ref_clk;

  ecfg_top #(.MEM_WORDS(16), .LOAD_WORDS(2)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cfg_rom_clock_in(ck_pin), .cfg_rom_clock_out(sck), .cfg_rom_clock_oe(sck_oe), .cfg_rom_serial_out(sout),
    .cfg_rom_serial_in(sdi), .cfg_rom_select_n_in(sel_pin), .cfg_rom_select_n_out(seln),
    .cfg_rom_select_n_oe(seln_oe), .debug_out_pins_in(dbg_pin), .debug_out_pins_out(dbg_out),
    .debug_out_pins_oe(dbg_oe), .mgmt_i2c_strap(i2c_pin), .gpio_in(gpio), .strap_done(done),
    .cfg_rom_enabled(en), .mgmt_i2c_mode(i2c), .operation_mode_strap(opm), .upstream_port_choice(ups),
    .payload_cap_strap(pay), .lane_mode(lane), .debug_mode_active(act), .debug_mode_code(code));

  ecfg_rom_model mem_u (.sck(ck_pin), .sel_n(sel_pin), .sdi(sout), .sdo(sdi));

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task wait_bit(input int b);
    for (int n = 0; n < 4000; n++) begin
      rd(`ECFG_STATUS);
      if (rv[b] === 1'b1) break;
    end
    chk({31'h0, rv[b]}, 32'h0000_0001);
  endtask

  // both pin and register views of the latched straps
  task chk_straps(input int i);
    logic [4:0] d;
    d = dbg_t[i];
    chk(32'({done, en, i2c, opm, ups, pay, 2'(lane), act, code, dbg_oe}),
      32'({1'b1, 1'(i < 2), i[0], d[2:0], d[4:3], d[0], 2'(i), |d[2:0],
           gp_t[i][4:0], 5'h1F}));
    rd(`ECFG_STRAPS);
    chk(rv, {16'h0, gp_t[i][4:0], |d[2:0], 2'(i), d[0], d[4:3], d[2:0], i[0], 1'(i < 2)});
  endtask

  task do_reset(input int i);
    @(posedge ref_clk);
    reset_n   <= 1'b0;
    sel_strap <= 1'(i < 2);
    i2c_pin   <= i[0];
    dbg_pin   <= dbg_t[i];
    gpio      <= gp_t[i];
    repeat (3) @(posedge ref_clk);
    chk(32'({seln, seln_oe, sck_oe, done}), 32'h0000_0008);
    reset_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk_straps(i);
  endtask

  task mem_test;
    wait_bit(`ECFG_STAT_LOADED);
    for (int k = 0; k < 2; k++) begin
      wr(`ECFG_MEM_INDEX, 32'(k));
      rd(`ECFG_MEM_DATA);
      chk(rv, {16'h0, mem_u.mem[k]});
    end
    wr(`ECFG_STATUS, 32'h0000_0002);
    wr(`ECFG_WDATA, 32'h0000_BEEF);
    // top address, write opcode
    wr(`ECFG_CTRL, 32'h0000_3F03);
    wait_bit(`ECFG_STAT_DONE);
    chk({16'h0, mem_u.mem[63]}, 32'h0000_BEEF);
    wr(`ECFG_STATUS, 32'h0000_0002);
    wr(`ECFG_CTRL, 32'h0000_3F05);
    wait_bit(`ECFG_STAT_DONE);
    rd(`ECFG_RDATA);
    chk(rv, 32'h0000_BEEF);
    // debug code from general pins picks the bit count, full after a frame
    chk({27'h0, dbg_out}, 32'(`ECFG_FRAME_W));
  endtask

  initial begin
    reset_n         = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0000_0000;
    reg_write       = 1'b0;
    reg_read        = 1'b0;
    sel_strap       = 1'b1;
    i2c_pin         = 1'b0;
    dbg_pin         = 5'h00;
    gpio            = 8'h00;
    failures        = 0;
    samples_checked = 0;
    for (int i = 0; i < 3; i++) begin
      do_reset(i);
      // later pin activity must not reach the latched values
      gpio    <= ~gp_t[i];
      i2c_pin <= ~i[0];
      dbg_pin <= ~dbg_t[i];
      sel_strap <= ~sel_strap;
      repeat (8) @(posedge ref_clk);
      chk_straps(i);
      if (i == 0) mem_test;
      if (i == 1) begin
        // normal mode: debug word follows the source register
        wr(`ECFG_DBG_SRC, 32'h0000_0002);
        rd(`ECFG_DBG_SRC);
        chk(rv, 32'h0000_0002);
        chk({28'h0, dbg_out[4:1]}, 32'h0000_0003);
      end
      if (i == 2) begin
        wr(`ECFG_CTRL, 32'h0000_0005);
        repeat (200) @(posedge ref_clk);
        rd(`ECFG_STATUS);
        chk(rv & 32'h0000_0007, 32'h0000_0000);
      end
      $display("strap set %0d finished", i);
    end
    report_and_stop;
  end

  // tests need about 13000 cycles
  initial begin
    #200000;
    failures++;
    report_and_stop;
  end
endmodule
